// ### logic/ptr_cmp_pkg.sv
/*
 Package for the pointer compare block: status word bit positions,
 operand widths, compare kinds and timing constants.
 Assumes nothing of its surroundings.
*/
package ptr_cmp_pkg;
   // ************************************************************
   // Widths and flag positions
   // ************************************************************
   localparam int PTR_W   = 24;
   localparam int WORD_W  = 16;
   localparam int SW_W    = 16;
   localparam int FULL_MSB = PTR_W - 1;
   localparam int WORD_MSB = WORD_W - 1;
   localparam int BIT_C   = 0;
   localparam int BIT_V   = 1;
   localparam int BIT_Z   = 2;
   localparam int BIT_N   = 3;
   localparam logic [15:0] SW_RESET = 16'h0300;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_NS       = 4;
   localparam int PTR_CYCLES   = 1;
   localparam int DATA_MIN_CYC = 1;
   localparam int DATA_MAX_CYC = 3;

   typedef enum logic [1:0] {
      CMP_NONE,
      CMP_FULL,
      CMP_WORD
   } cmp_kind_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   typedef struct packed {
      cmp_kind_t          kind;
      logic [PTR_W-1:0]   src;
      logic [PTR_W-1:0]   dst;
   } ptr_req_t;
endpackage

// ### logic/ptr_sub_flags.sv
/*
 Subtractor that forms the compare flags for a 24-bit or 16-bit compare.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
module ptr_sub_flags (
   // Operands
   input  wire logic [ptr_cmp_pkg::PTR_W-1:0] dst,
   input  wire logic [ptr_cmp_pkg::PTR_W-1:0] src,
   input  wire logic                          wordMode,
   // Result
   output var ptr_cmp_pkg::flags_t            flags
);
   logic [ptr_cmp_pkg::PTR_W:0]  diffFull;
   logic [ptr_cmp_pkg::WORD_W:0] diffWord;

   always_comb begin
      diffFull = {1'b0, dst} - {1'b0, src};
      diffWord = {1'b0, dst[ptr_cmp_pkg::WORD_MSB:0]}
               - {1'b0, src[ptr_cmp_pkg::WORD_MSB:0]};
      if (wordMode) begin
         // Upper pointer bits never reach a flag
         flags.n = diffWord[ptr_cmp_pkg::WORD_MSB];
         flags.z = (diffWord[ptr_cmp_pkg::WORD_MSB:0] == '0);
         flags.v = (dst[ptr_cmp_pkg::WORD_MSB] != src[ptr_cmp_pkg::WORD_MSB])
                 && (diffWord[ptr_cmp_pkg::WORD_MSB]
                     != dst[ptr_cmp_pkg::WORD_MSB]);
         flags.c = diffWord[ptr_cmp_pkg::WORD_W];
      end else begin
         flags.n = diffFull[ptr_cmp_pkg::FULL_MSB];
         flags.z = (diffFull[ptr_cmp_pkg::FULL_MSB:0] == '0);
         flags.v = (dst[ptr_cmp_pkg::FULL_MSB] != src[ptr_cmp_pkg::FULL_MSB])
                 && (diffFull[ptr_cmp_pkg::FULL_MSB]
                     != dst[ptr_cmp_pkg::FULL_MSB]);
         flags.c = diffFull[ptr_cmp_pkg::PTR_W];
      end
   end
endmodule // ptr_sub_flags
`default_nettype wire

// ### logic/address_register_compare.sv
/*
 Pointer compare execution: full-width and word compares of two
 address_generation_unit pointers, updating the status_word flags.
 Assumes the sequencer presents one compare per cycle with operands
 valid in the same cycle, and holds the status word here.
*/
//
// Contract
// - Full compare subtracts 24-bit source from destination
// - Difference discarded; pointers unchanged, only flags
// - Full compare negative flag from bit 23
// - Zero flag set when difference is zero
// - Overflow flag set on signed overflow
// - Full compare carry on borrow from bit 23
// - Full compare: one word, one cycle
// - Word compare uses only low 16 bits
// - Data word compare takes 1 to 3 cycles
// - Word compare negative flag from bit 15
// - Word compare carry on borrow from bit 15
// - Word compare: one word, one cycle
`timescale 1ns/1ns
`default_nettype none
module address_register_compare (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          srst,
   // Request from the sequencer
   input  wire ptr_cmp_pkg::ptr_req_t         req,
   // Status word load from the sequencer
   input  wire logic                          swLoad,
   input  wire logic [ptr_cmp_pkg::SW_W-1:0]  swLoadValue,
   // Data word compare occupancy
   input  wire logic                          dataCmpStart,
   input  wire logic [1:0]                    dataCmpCycles,
   // Results
   output logic [ptr_cmp_pkg::SW_W-1:0]       status_word_reg,
   output logic                               cmpDone_reg,
   output logic                               dataCmpBusy_reg
);
   // ************************************************************
   // Flag computation
   // ************************************************************
   ptr_cmp_pkg::flags_t flagsNew;
   logic                isCmp;

   ptr_sub_flags u_sub (
      .dst      (req.dst),
      .src      (req.src),
      .wordMode (req.kind == ptr_cmp_pkg::CMP_WORD),
      .flags    (flagsNew)
   );

   assign isCmp = (req.kind == ptr_cmp_pkg::CMP_FULL)
               || (req.kind == ptr_cmp_pkg::CMP_WORD);

   // ************************************************************
   // Status word
   // ************************************************************
   // A compare writes only N, Z, V, C; a status load writes the whole word only in a cycle without a compare; pointers are inputs, never stored
   always_ff @(posedge mclk) begin
      if (srst) begin
         status_word_reg <= ptr_cmp_pkg::SW_RESET;
      end else if (isCmp) begin
         status_word_reg[ptr_cmp_pkg::BIT_N] <= flagsNew.n;
         status_word_reg[ptr_cmp_pkg::BIT_Z] <= flagsNew.z;
         status_word_reg[ptr_cmp_pkg::BIT_V] <= flagsNew.v;
         status_word_reg[ptr_cmp_pkg::BIT_C] <= flagsNew.c;
      end else if (swLoad) begin
         status_word_reg <= swLoadValue;
      end
   end

   // Single-cycle completion for both pointer forms
   always_ff @(posedge mclk) begin
      if (srst) begin
         cmpDone_reg <= 1'b0;
      end else begin
         cmpDone_reg <= isCmp;
      end
   end

   // ************************************************************
   // Data word compare occupancy
   // ************************************************************
   // Cycle count is clamped to the legal span of the addressing forms
   logic [1:0] busyCnt_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         busyCnt_reg     <= 2'h0;
         dataCmpBusy_reg <= 1'b0;
      end else if (dataCmpStart && busyCnt_reg == 2'h0) begin
         if (dataCmpCycles > 2'(ptr_cmp_pkg::DATA_MIN_CYC)) begin
            busyCnt_reg <= (dataCmpCycles > 2'(ptr_cmp_pkg::DATA_MAX_CYC))
                         ? 2'(ptr_cmp_pkg::DATA_MAX_CYC - 1)
                         : 2'(dataCmpCycles - 2'h1);
            dataCmpBusy_reg <= 1'b1;
         end
      end else if (busyCnt_reg != 2'h0) begin
         busyCnt_reg     <= busyCnt_reg - 2'h1;
         dataCmpBusy_reg <= (busyCnt_reg != 2'h1);
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   localparam logic [15:0] KEEP_MASK = 16'hFFF0;

   // Reference differences built apart from the subtractor, so a fault
   // there cannot hide in the checks
   logic [ptr_cmp_pkg::PTR_W:0]    fullExt;
   logic [ptr_cmp_pkg::WORD_W-1:0] wordDiff;

   assign fullExt  = {req.dst[ptr_cmp_pkg::FULL_MSB], req.dst}
                   - {req.src[ptr_cmp_pkg::FULL_MSB], req.src};
   assign wordDiff = req.dst[ptr_cmp_pkg::WORD_MSB:0]
                   - req.src[ptr_cmp_pkg::WORD_MSB:0];

   property p_keep_other;
      @(posedge mclk) disable iff (srst)
      isCmp |=> ((status_word_reg & KEEP_MASK)
                 == ($past(status_word_reg) & KEEP_MASK));
   endproperty
   a_keep_other: assert property (p_keep_other)
      else $error("compare changed undefined flags");

   property p_zero_full;
      @(posedge mclk) disable iff (srst)
      (req.kind == ptr_cmp_pkg::CMP_FULL && req.src == req.dst)
      |=> status_word_reg[ptr_cmp_pkg::BIT_Z]
          && !status_word_reg[ptr_cmp_pkg::BIT_C];
   endproperty
   a_zero_full: assert property (p_zero_full)
      else $error("equal pointers not flagged zero");

   property p_word_upper;
      @(posedge mclk) disable iff (srst)
      (req.kind == ptr_cmp_pkg::CMP_WORD
       && req.src[ptr_cmp_pkg::WORD_MSB:0]
          == req.dst[ptr_cmp_pkg::WORD_MSB:0])
      |=> status_word_reg[ptr_cmp_pkg::BIT_Z];
   endproperty
   a_word_upper: assert property (p_word_upper)
      else $error("word compare saw upper bits");

   property p_borrow_full;
      @(posedge mclk) disable iff (srst)
      (req.kind == ptr_cmp_pkg::CMP_FULL && req.src > req.dst)
      |=> status_word_reg[ptr_cmp_pkg::BIT_C];
   endproperty
   a_borrow_full: assert property (p_borrow_full)
      else $error("missing borrow on full compare");

   property p_borrow_word;
      @(posedge mclk) disable iff (srst)
      (req.kind == ptr_cmp_pkg::CMP_WORD
       && req.src[ptr_cmp_pkg::WORD_MSB:0]
          > req.dst[ptr_cmp_pkg::WORD_MSB:0])
      |=> status_word_reg[ptr_cmp_pkg::BIT_C];
   endproperty
   a_borrow_word: assert property (p_borrow_word)
      else $error("missing borrow on word compare");

   property p_neg_full;
      @(posedge mclk) disable iff (srst)
      req.kind == ptr_cmp_pkg::CMP_FULL
      |=> status_word_reg[ptr_cmp_pkg::BIT_N]
          == $past(fullExt[ptr_cmp_pkg::FULL_MSB]);
   endproperty
   a_neg_full: assert property (p_neg_full)
      else $error("negative flag wrong on full compare");

   property p_word_neg;
      @(posedge mclk) disable iff (srst)
      req.kind == ptr_cmp_pkg::CMP_WORD
      |=> status_word_reg[ptr_cmp_pkg::BIT_N]
          == $past(wordDiff[ptr_cmp_pkg::WORD_MSB]);
   endproperty
   a_word_neg: assert property (p_word_neg)
      else $error("negative flag wrong on word compare");

   // Overflow seen as the sign-extended difference leaving its range
   property p_ovf_full;
      @(posedge mclk) disable iff (srst)
      req.kind == ptr_cmp_pkg::CMP_FULL
      |=> status_word_reg[ptr_cmp_pkg::BIT_V]
          == $past(fullExt[ptr_cmp_pkg::PTR_W]
                   != fullExt[ptr_cmp_pkg::FULL_MSB]);
   endproperty
   a_ovf_full: assert property (p_ovf_full)
      else $error("overflow flag wrong on full compare");

   property p_load;
      @(posedge mclk) disable iff (srst)
      (swLoad && !isCmp) |=> status_word_reg == $past(swLoadValue);
   endproperty
   a_load: assert property (p_load)
      else $error("status load lost");

   property p_done_clear;
      @(posedge mclk) disable iff (srst)
      !isCmp |=> !cmpDone_reg;
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("done raised without a compare");

   property p_done;
      @(posedge mclk) disable iff (srst)
      isCmp |=> cmpDone_reg ##1 (cmpDone_reg == $past(isCmp));
   endproperty
   a_done: assert property (p_done)
      else $error("compare not done in one cycle");

   sequence s_busy_span;
      dataCmpBusy_reg ##[1:2] !dataCmpBusy_reg;
   endsequence
   property p_data_span;
      @(posedge mclk) disable iff (srst)
      $rose(dataCmpBusy_reg) |-> s_busy_span;
   endproperty
   a_data_span: assert property (p_data_span)
      else $error("data compare exceeded three cycles");

   property p_short_data;
      @(posedge mclk) disable iff (srst)
      (dataCmpStart && !dataCmpBusy_reg
       && dataCmpCycles <= 2'(ptr_cmp_pkg::DATA_MIN_CYC))
      |=> !dataCmpBusy_reg;
   endproperty
   a_short_data: assert property (p_short_data)
      else $error("single cycle data compare showed busy");

   // A start that lands while busy must not stretch the span
   sequence s_busy_start;
      dataCmpStart && dataCmpBusy_reg;
   endsequence
   property p_busy_ignore;
      @(posedge mclk) disable iff (srst)
      s_busy_start |-> ##[1:2] !dataCmpBusy_reg;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("start while busy extended data compare");
endmodule // address_register_compare
`default_nettype wire

// ### test/cmp_seq_model.sv
/*
 Sequencer model: drives compare requests, status word loads and
 data compare starts. Assumes the bench supplies the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cmp_seq_model (
   // Clock
   input  wire logic                 mclk,
   // Sequencer outputs
   output var ptr_cmp_pkg::ptr_req_t req,
   output var logic                  swLoad,
   output var logic [15:0]           swLoadValue,
   output var logic                  dataCmpStart,
   output var logic [1:0]            dataCmpCycles
);
   initial begin
      req = '{ptr_cmp_pkg::CMP_NONE, 24'h0, 24'h0};
      swLoad = 1'b0;
      swLoadValue = 16'h0;
      dataCmpStart = 1'b0;
      dataCmpCycles = 2'h0;
   end
   task automatic drive(input ptr_cmp_pkg::cmp_kind_t k,
                        input logic [23:0] s, d,
                        input logic ld, input logic [15:0] lv);
      @(posedge mclk);
      req <= '{k, s, d};
      swLoad <= ld;
      swLoadValue <= lv;
   endtask
   // Released operands flip so a stale value never passes for a live one
   task automatic idle();
      @(posedge mclk);
      req <= '{ptr_cmp_pkg::CMP_NONE, ~req.src, ~req.dst};
      swLoad <= 1'b0;
      swLoadValue <= ~swLoadValue;
   endtask
   task automatic dstart(input logic [1:0] n);
      @(posedge mclk);
      dataCmpStart <= 1'b1;
      dataCmpCycles <= n;
      @(posedge mclk);
      dataCmpStart <= 1'b0;
      dataCmpCycles <= ~n;
   endtask
endmodule // cmp_seq_model
`default_nettype wire

// ### test/address_register_compare_tb_top.sv
/*
 Testbench for the pointer compare block: compares, status loads,
 data compare occupancy. Assumes the sequencer model beside it.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module address_register_compare_tb_top;
   logic                  mclk, srst, swLoad, dataCmpStart, done, busy;
   ptr_cmp_pkg::ptr_req_t req;
   logic [15:0]           swLoadValue, sw, expSw;
   logic [1:0]            dataCmpCycles;
   logic [23:0]           vs [7], vd [7];
   logic                  vw [7];
   int                    checks, fail_count, cnt;
   address_register_compare u_address_register_compare (.mclk(mclk),
      .srst(srst), .req(req), .swLoad(swLoad), .swLoadValue(swLoadValue),
      .dataCmpStart(dataCmpStart), .dataCmpCycles(dataCmpCycles),
      .status_word_reg(sw), .cmpDone_reg(done), .dataCmpBusy_reg(busy));
   cmp_seq_model u_cmp_seq_model (.mclk(mclk), .req(req), .swLoad(swLoad),
      .swLoadValue(swLoadValue), .dataCmpStart(dataCmpStart),
      .dataCmpCycles(dataCmpCycles));
   // Flags from the compared width only; upper status bits carried over
   function automatic logic [15:0] expect_sw(input logic w,
      input logic [23:0] s, d, input logic [15:0] prev);
      logic [23:0] mk;
      logic [23:0] df;
      int          m;
      mk = w ? 24'h00FFFF : 24'hFFFFFF;
      m = w ? ptr_cmp_pkg::WORD_MSB : ptr_cmp_pkg::FULL_MSB;
      s = s & mk;
      d = d & mk;
      df = (d - s) & mk;
      return {prev[15:4], df[m], df == 24'h0,
              (d[m] != s[m]) && (df[m] != d[m]), s > d};
   endfunction
   task automatic summarize();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
   initial begin
      srst = 1'b1;
      vs = '{24'h082473, 24'h082473, 24'hFFFFFF, 24'hFF8000, 24'h3, 24'h1,
             24'h654321};
      vd = '{24'h002473, 24'h002473, 24'h7FFFFF, 24'h007FFF, 24'h5,
             24'hFF0000, 24'h654321};
      vw = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      #1 `CHK(sw, ptr_cmp_pkg::SW_RESET)
      expSw = ptr_cmp_pkg::SW_RESET;
      // Back to back, each with a losing status load in the same cycle
      for (int i = 0; i < 8; i++) begin
         if (i < 7)
            u_cmp_seq_model.drive(vw[i] ? ptr_cmp_pkg::CMP_WORD :
               ptr_cmp_pkg::CMP_FULL, vs[i], vd[i], 1'b1, 16'hFFFF);
         else
            u_cmp_seq_model.idle();
         if (i > 0) begin
            expSw = expect_sw(vw[i-1], vs[i-1], vd[i-1], expSw);
            #1 `CHK(sw, expSw)
            `CHK(done, 1'b1)
         end
      end
      @(posedge mclk);
      #1 `CHK(done, 1'b0)
      `CHK(sw, expSw)
      u_cmp_seq_model.drive(ptr_cmp_pkg::CMP_NONE, 24'h0, 24'h0, 1'b1,
                            16'hA5F0);
      u_cmp_seq_model.drive(ptr_cmp_pkg::CMP_WORD, 24'h120000, 24'h340000,
                            1'b0, 16'h0);
      #1 `CHK(sw, 16'hA5F0)
      u_cmp_seq_model.idle();
      #1 `CHK(sw, 16'hA5F4)
      for (int n = 0; n < 4; n++) begin
         u_cmp_seq_model.dstart(n[1:0]);
         cnt = 0;
         repeat (5) begin
            #1 cnt += int'(busy !== 1'b0);
            @(posedge mclk);
         end
         `CHK(cnt, (n < 2) ? 0 : n - 1)
      end
      // A start while busy is dropped, so the span does not grow
      u_cmp_seq_model.dstart(2'h3);
      u_cmp_seq_model.dstart(2'h3);
      cnt = 0;
      repeat (5) begin
         #1 cnt += int'(busy !== 1'b0);
         @(posedge mclk);
      end
      `CHK(cnt, 0)
      // A compare that meets reset must leave neither flags nor done
      u_cmp_seq_model.drive(ptr_cmp_pkg::CMP_FULL, 24'h000001, 24'h000002,
                            1'b0, 16'h0);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      #1 `CHK(sw, ptr_cmp_pkg::SW_RESET)
      `CHK(done, 1'b0)
      summarize();
   end
endmodule // address_register_compare_tb_top
`default_nettype wire
